/* fsrc_consts.vh */
`ifndef FSRC_CONSTS_VH
`define FSRC_CONSTS_VH

// Reset sequencing
`define FSRC_STRETCH_CYCLES 2097152
`define FSRC_STRETCH_W 22
`define FSRC_WIN_CYCLES 32
`define FSRC_WIN_W 6

// Boot addresses (word addresses)
`define FSRC_ADDR_W 21
`define FSRC_BOOT_INT_ADDR 21'h020000
`define FSRC_BOOT_EXT_ADDR 21'h000000

// Security byte pattern that means secured; erased flash reads unsecured
`define FSRC_SEC_KEY 16'he70a

// Test port instruction register
`define FSRC_IR_W 4
`define FSRC_IR_CAPTURE 4'h1
`define FSRC_IR_SAMPLE 4'h1
`define FSRC_IR_IDCODE 4'h2
`define FSRC_IR_LOCKOUT 4'h8
`define FSRC_IR_BYPASS 4'hf

// Data registers
`define FSRC_SR_W 32
`define FSRC_ID_W 32
`define FSRC_DIV_W 7
`define FSRC_DIV_PRESCALE_BIT 6
`define FSRC_DIV_FIELD_MSB 5
`define FSRC_DIV_RESET 7'h00

`endif

/* fsrc_top.v */
// How it works
// - Four reset sources: async pin and power-on, sync software and watchdog.
// - Power-on reset is stretched two to the twenty-first system clocks.
// - Then three 32-clock windows: clocking, peripheral release, core init, then run.
// - Pin and power-on resets assert asynchronously, release only on a rising system clock edge.
// - Two nonvolatile security bytes set security; state persists across resets.
// - Secured: block external program space, external boot and core debug.
// - Secured boot is internal, fetching from word address 0x02_0000.
// - Secured: external boot select pin during reset is ignored.
// - Test port active at boot: boundary sample and identification readable.
// - During pin or power-on reset, debug memory read disable is forced on whatever the security bytes.
// - Lockout recovery erases all flash, clearing security.
// - Recovery instruction selects a 7-bit flash clock divider register.
// - During recovery bit 6 drives prescale, bits 5..0 drive divisor.
// - Load instruction, shift divider, hold Run-Test/Idle; erase runs until done.
`timescale 1ns/100ps
`default_nettype none
`include "fsrc_consts.vh"

module fsrc_top #(
  parameter STRETCH_CYCLES = `FSRC_STRETCH_CYCLES,
  parameter WIN_CYCLES = `FSRC_WIN_CYCLES,
  parameter BSR_W = 16,
  parameter [`FSRC_ID_W-1:0] ID_CODE = 32'h1234_5001 // Arbitrary value, names no real part
) (
  input wire clock_i,
  input wire nrst_i,
  input wire ce_i,
  input wire por_n_i,
  input wire ext_rst_n_i,
  input wire sw_reset_i,
  input wire watchdog_reset_i,
  input wire external_boot_select_i,
  input wire [7:0] sec_byte0_i,
  input wire [7:0] sec_byte1_i,
  input wire [BSR_W-1:0] scan_pins_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  input wire trst_n_i,
  input wire erase_done_i,
  output reg sys_clk_en_o,
  output reg periph_rst_n_o,
  output reg core_rst_n_o,
  output reg run_o,
  output reg secured_o,
  output reg ext_pspace_block_o,
  output reg ext_boot_mode_o,
  output reg debug_enable_o,
  output reg debug_read_disable_o,
  output reg [`FSRC_ADDR_W-1:0] boot_addr_o,
  output reg tdo_o,
  output reg tdo_oe_o,
  output reg erase_o,
  output reg recovery_done_o,
  output reg div_override_o,
  output reg prescale_by_eight_o,
  output reg [`FSRC_DIV_FIELD_MSB:0] flash_divisor_o
);

  localparam ST_HOLD = 3'd0;
  localparam ST_STRETCH = 3'd1;
  localparam ST_CLK = 3'd2;
  localparam ST_PERIPH = 3'd3;
  localparam ST_CORE = 3'd4;
  localparam ST_RUN = 3'd5;
  localparam TLR = 4'd0;
  localparam RTI = 4'd1;
  localparam SEL_DR = 4'd2;
  localparam CAP_DR = 4'd3;
  localparam SH_DR = 4'd4;
  localparam EX1_DR = 4'd5;
  localparam PA_DR = 4'd6;
  localparam EX2_DR = 4'd7;
  localparam UP_DR = 4'd8;
  localparam SEL_IR = 4'd9;
  localparam CAP_IR = 4'd10;
  localparam SH_IR = 4'd11;
  localparam EX1_IR = 4'd12;
  localparam PA_IR = 4'd13;
  localparam EX2_IR = 4'd14;
  localparam UP_IR = 4'd15;
  function sec_decode;
    input [7:0] b0;
    input [7:0] b1;
    begin
      sec_decode = ({b1, b0} == `FSRC_SEC_KEY);
    end
  endfunction

  function [3:0] tap_next;
    input [3:0] s;
    input m;
    begin
      case (s)
        TLR: tap_next = m ? TLR : RTI;
        RTI: tap_next = m ? SEL_DR : RTI;
        SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
        CAP_DR: tap_next = m ? EX1_DR : SH_DR;
        SH_DR: tap_next = m ? EX1_DR : SH_DR;
        EX1_DR: tap_next = m ? UP_DR : PA_DR;
        PA_DR: tap_next = m ? EX2_DR : PA_DR;
        EX2_DR: tap_next = m ? UP_DR : SH_DR;
        UP_DR: tap_next = m ? SEL_DR : RTI;
        SEL_IR: tap_next = m ? TLR : CAP_IR;
        CAP_IR: tap_next = m ? EX1_IR : SH_IR;
        SH_IR: tap_next = m ? EX1_IR : SH_IR;
        EX1_IR: tap_next = m ? UP_IR : PA_IR;
        PA_IR: tap_next = m ? EX2_IR : PA_IR;
        EX2_IR: tap_next = m ? UP_IR : SH_IR;
        UP_IR: tap_next = m ? SEL_DR : RTI;
        default: tap_next = TLR;
      endcase
    end
  endfunction

  // Reset combining and release synchroniser
  wire rst_any_n = nrst_i & por_n_i & ext_rst_n_i;
  wire tap_rst_n = nrst_i & por_n_i;
  reg rst_meta;
  reg rst_sync;
  reg por_pending;
  reg [2:0] state;
  reg [`FSRC_STRETCH_W-1:0] cnt;
  reg [2:0] next_state;
  reg [`FSRC_STRETCH_W-1:0] next_cnt;
  wire sync_req = sw_reset_i | watchdog_reset_i;
  wire [31:0] stretch_full = STRETCH_CYCLES - 1;
  wire [31:0] win_full = WIN_CYCLES - 1;
  wire [`FSRC_STRETCH_W-1:0] stretch_last = stretch_full[`FSRC_STRETCH_W-1:0];
  wire [`FSRC_STRETCH_W-1:0] win_last = win_full[`FSRC_STRETCH_W-1:0];
  wire secure_now = sec_decode(sec_byte0_i, sec_byte1_i);
  always @(posedge clock_i or negedge rst_any_n) begin
    if (!rst_any_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else if (ce_i) begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  // Only a power-on event earns the long stretch
  always @(posedge clock_i or negedge por_n_i) begin
    if (!por_n_i) begin
      por_pending <= 1'b1;
    end else if (ce_i && state == ST_STRETCH && cnt == stretch_last) begin
      por_pending <= 1'b0;
    end
  end
  always @* begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    if (!rst_sync) begin
      next_state = ST_HOLD;
      next_cnt = {`FSRC_STRETCH_W{1'b0}};
    end else if (sync_req) begin
      next_state = ST_CLK;
      next_cnt = {`FSRC_STRETCH_W{1'b0}};
    end else begin
      case (state)
        ST_HOLD: begin
          next_state = por_pending ? ST_STRETCH : ST_CLK;
          next_cnt = {`FSRC_STRETCH_W{1'b0}};
        end
        ST_STRETCH: begin
          if (cnt == stretch_last) begin
            next_state = ST_CLK;
            next_cnt = {`FSRC_STRETCH_W{1'b0}};
          end
        end
        ST_CLK, ST_PERIPH, ST_CORE: begin
          if (cnt == win_last) begin
            next_state = state + 3'd1;
            next_cnt = {`FSRC_STRETCH_W{1'b0}};
          end
        end
        ST_RUN: next_cnt = cnt;
        default: begin
          next_state = ST_HOLD;
          next_cnt = {`FSRC_STRETCH_W{1'b0}};
        end
      endcase
    end
  end

  // Security defaults to locked while in pin or power-on reset so nothing leaks before capture
  always @(posedge clock_i or negedge rst_any_n) begin
    if (!rst_any_n) begin
      state <= ST_HOLD;
      cnt <= {`FSRC_STRETCH_W{1'b0}};
      sys_clk_en_o <= 1'b0;
      periph_rst_n_o <= 1'b0;
      core_rst_n_o <= 1'b0;
      run_o <= 1'b0;
      secured_o <= 1'b1;
      ext_pspace_block_o <= 1'b1;
      ext_boot_mode_o <= 1'b0;
      debug_enable_o <= 1'b0;
      debug_read_disable_o <= 1'b1;
      boot_addr_o <= `FSRC_BOOT_INT_ADDR;
    end else if (ce_i) begin
      state <= next_state;
      cnt <= next_cnt;
      sys_clk_en_o <= (next_state >= ST_CLK);
      periph_rst_n_o <= (next_state >= ST_PERIPH);
      core_rst_n_o <= (next_state >= ST_CORE);
      run_o <= (next_state == ST_RUN);
      if (next_state == ST_PERIPH && state != ST_PERIPH) begin
        // Bytes are recaptured on every reset, so the lock persists
        secured_o <= secure_now;
        ext_pspace_block_o <= secure_now;
        debug_enable_o <= ~secure_now;
        debug_read_disable_o <= secure_now;
        ext_boot_mode_o <= external_boot_select_i & ~secure_now;
        boot_addr_o <= (external_boot_select_i & ~secure_now) ?
          `FSRC_BOOT_EXT_ADDR : `FSRC_BOOT_INT_ADDR;
      end
    end
  end

  // Test port, sampled on the system clock; needs clock_i well above tck_i
  reg tck_q;
  reg [3:0] tap;
  reg [`FSRC_IR_W-1:0] ir;
  reg [`FSRC_IR_W-1:0] ir_sr;
  reg [`FSRC_SR_W-1:0] dr_sr;
  reg [`FSRC_DIV_W-1:0] clkdiv;
  reg div_loaded;
  reg recovering;
  wire tck_rise = tck_i & ~tck_q;
  wire tck_fall = ~tck_i & tck_q;
  wire [3:0] tap_nx = tap_next(tap, tms_i);
  wire is_lock = (ir == `FSRC_IR_LOCKOUT);
  wire is_id = (ir == `FSRC_IR_IDCODE);
  wire is_smp = (ir == `FSRC_IR_SAMPLE);
  reg [`FSRC_SR_W-1:0] dr_shifted;
  always @* begin
    dr_shifted = dr_sr >> 1;
    if (is_id) begin
      dr_shifted[`FSRC_ID_W-1] = tdi_i;
    end else if (is_smp) begin
      dr_shifted[BSR_W-1] = tdi_i;
    end else if (is_lock) begin
      dr_shifted[`FSRC_DIV_W-1] = tdi_i;
    end else begin
      dr_shifted[0] = tdi_i;
    end
  end
  always @(posedge clock_i or negedge tap_rst_n) begin
    if (!tap_rst_n) begin
      tck_q <= 1'b0;
      tap <= TLR;
      ir <= `FSRC_IR_IDCODE;
      ir_sr <= `FSRC_IR_CAPTURE;
      dr_sr <= {`FSRC_SR_W{1'b0}};
      clkdiv <= `FSRC_DIV_RESET;
      div_loaded <= 1'b0;
      recovering <= 1'b0;
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
      erase_o <= 1'b0;
      recovery_done_o <= 1'b0;
      div_override_o <= 1'b0;
      prescale_by_eight_o <= 1'b0;
      flash_divisor_o <= {(`FSRC_DIV_FIELD_MSB+1){1'b0}};
    end else if (ce_i) begin
      tck_q <= tck_i;
      if (!trst_n_i) begin
        tap <= TLR;
        ir <= `FSRC_IR_IDCODE;
        div_loaded <= 1'b0;
        recovering <= 1'b0;
        recovery_done_o <= 1'b0;
        tdo_oe_o <= 1'b0;
      end else begin
        if (tck_rise) begin
          tap <= tap_nx;
          case (tap)
            TLR: begin
              ir <= `FSRC_IR_IDCODE;
              div_loaded <= 1'b0;
            end
            CAP_IR: ir_sr <= `FSRC_IR_CAPTURE;
            SH_IR: ir_sr <= {tdi_i, ir_sr[`FSRC_IR_W-1:1]};
            UP_IR: begin
              ir <= ir_sr;
              div_loaded <= 1'b0;
            end
            CAP_DR: begin
              if (is_id) begin
                dr_sr <= ID_CODE;
              end else if (is_smp) begin
                dr_sr <= {{(`FSRC_SR_W-BSR_W){1'b0}}, scan_pins_i};
              end else if (is_lock) begin
                dr_sr <= {{(`FSRC_SR_W-`FSRC_DIV_W){1'b0}}, clkdiv};
              end else begin
                dr_sr <= {`FSRC_SR_W{1'b0}};
              end
            end
            SH_DR: dr_sr <= dr_shifted;
            UP_DR: begin
              if (is_lock) begin
                clkdiv <= dr_sr[`FSRC_DIV_W-1:0];
                div_loaded <= 1'b1;
              end
            end
            default: ;
          endcase
          // Erase starts on entry to Run-Test/Idle; leaving it aborts
          if (tap_nx == RTI && is_lock && !recovery_done_o &&
              ((div_loaded && tap != UP_IR) || tap == UP_DR)) begin
            recovering <= 1'b1;
          end else if (tap_nx != RTI) begin
            recovering <= 1'b0;
          end
        end
        if (recovering && erase_done_i) begin
          recovering <= 1'b0;
          recovery_done_o <= 1'b1;
        end
        if (tck_fall) begin
          tdo_oe_o <= (tap == SH_IR) || (tap == SH_DR);
          tdo_o <= (tap == SH_IR) ? ir_sr[0] : dr_sr[0];
        end
      end
      erase_o <= recovering & ~erase_done_i;
      div_override_o <= recovering;
      prescale_by_eight_o <= clkdiv[`FSRC_DIV_PRESCALE_BIT];
      flash_divisor_o <= clkdiv[`FSRC_DIV_FIELD_MSB:0];
    end
  end

endmodule
`default_nettype wire

/* fsrc_top_end.v */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* fsrc_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fsrc_consts.vh"
module fsrc_top_checker #(parameter WIN_CYCLES = 32) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic por_n_i,
  input wire logic ext_rst_n_i,
  input wire logic sw_reset_i,
  input wire logic watchdog_reset_i,
  input wire logic [7:0] sec_byte0_i,
  input wire logic [7:0] sec_byte1_i,
  input wire logic erase_done_i,
  input wire logic sys_clk_en_o,
  input wire logic periph_rst_n_o,
  input wire logic core_rst_n_o,
  input wire logic run_o,
  input wire logic secured_o,
  input wire logic ext_pspace_block_o,
  input wire logic ext_boot_mode_o,
  input wire logic debug_enable_o,
  input wire logic debug_read_disable_o,
  input wire logic erase_o,
  input wire logic div_override_o,
  input wire logic [`FSRC_ADDR_W-1:0] boot_addr_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  periph_win_a: assert property (
    $rose(periph_rst_n_o) |-> $past(sys_clk_en_o, WIN_CYCLES)) else $error("early periph");
  core_win_a: assert property (
    $rose(core_rst_n_o) |-> $past(periph_rst_n_o, WIN_CYCLES)
    && !$past(periph_rst_n_o, WIN_CYCLES + 1)) else $error("core window off");
  run_win_a: assert property (
    $rose(run_o) |-> $past(core_rst_n_o, WIN_CYCLES)
    && !$past(core_rst_n_o, WIN_CYCLES + 1)) else $error("run window off");
  pin_reset_a: assert property (
    !ext_rst_n_i || !por_n_i |-> !sys_clk_en_o && !periph_rst_n_o && !core_rst_n_o && !run_o)
    else $error("outputs live in reset");
  release_sync_a: assert property (
    $rose(sys_clk_en_o) |-> $past(ext_rst_n_i && por_n_i, 2)) else $error("release unsynced");
  sync_rst_a: assert property (
    sw_reset_i || watchdog_reset_i |-> ##[1:4] !periph_rst_n_o) else $error("no restart");
  secure_lock_a: assert property (
    secured_o |-> ext_pspace_block_o && debug_read_disable_o && !debug_enable_o
    && !ext_boot_mode_o && boot_addr_o == `FSRC_BOOT_INT_ADDR) else $error("lock open");
  sec_key_a: assert property (
    core_rst_n_o |-> secured_o == ({sec_byte1_i, sec_byte0_i} == `FSRC_SEC_KEY))
    else $error("security state wrong");
  erase_div_a: assert property (
    erase_o |-> div_override_o) else $error("erase without divider");
  erase_end_a: assert property (
    erase_o && erase_done_i |-> ##[1:2] !erase_o) else $error("erase not ended");
  ext_boot_a: assert property (
    ext_boot_mode_o |-> !secured_o && boot_addr_o == `FSRC_BOOT_EXT_ADDR)
    else $error("external boot wrong");
  cover property ($rose(run_o));
  cover property (secured_o && run_o);
  cover property ($rose(erase_o));
endmodule
bind fsrc_top fsrc_top_checker #(.WIN_CYCLES(WIN_CYCLES)) i_chk (.clock_i, .nrst_i,
  .por_n_i, .ext_rst_n_i, .sw_reset_i, .watchdog_reset_i, .sec_byte0_i, .sec_byte1_i,
  .erase_done_i, .sys_clk_en_o, .periph_rst_n_o, .core_rst_n_o, .run_o, .secured_o,
  .ext_pspace_block_o, .ext_boot_mode_o, .debug_enable_o, .debug_read_disable_o,
  .erase_o, .div_override_o, .boot_addr_o);
`default_nettype wire

/* fsrc_jtag_host.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fsrc_consts.vh"
module fsrc_jtag_host (
  input wire logic clock_i,
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  initial {tck_o, tms_o, tdi_o, trst_n_o} = 4'h4;
  // Eight system clocks a test clock, above the 4x oversampling need
  task automatic tick(input logic m, input logic d, output logic q);
    repeat (4) @(negedge clock_i);
    tck_o = 1'b0;
    tms_o = m;
    tdi_o = d;
    repeat (4) @(negedge clock_i);
    q = tdo_i;
    tck_o = 1'b1;
  endtask
  // Data line toggles when not shifting so stale bits are never reused
  task automatic move(input logic m);
    logic q;
    tick(m, ~tdi_o, q);
  endtask
  task automatic tap_reset();
    trst_n_o = 1'b0;
    repeat (5) move(1'b1);
    trst_n_o = 1'b1;
    move(1'b0);
  endtask
  task automatic shift(input logic ir, input logic [31:0] v, input int n,
                       output logic [31:0] q);
    logic b;
    q = '0;
    move(1'b1);
    if (ir) move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, v[i], b);
      q[i] = b;
    end
    move(1'b1);
    move(1'b0);
  endtask
  // 100 MHz input, prescale on, /8 then /64 gives 195 kHz
  task automatic recover();
    logic [31:0] q;
    shift(1'b1, `FSRC_IR_LOCKOUT, 4, q);
    shift(1'b0, 32'h7f, 7, q);
  endtask
  task automatic idle(input int n);
    repeat (n) move(1'b0);
  endtask
endmodule
`default_nettype wire

/* test_flash_security_reset_control.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fsrc_consts.vh"
module test_flash_security_reset_control;
  logic clock_i = 1'b0, nrst_i = 1'b0, por_n = 1'b0, ext_n = 1'b0, sw = 1'b0, wd = 1'b0;
  logic sel = 1'b0, edone = 1'b0, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [7:0] b0 = 8'hff, b1 = 8'hff;
  logic [15:0] pins = 16'h0000;
  logic clk_en, per_n, core_n, run, sec, pblk, xboot, dbg, rdis, erase, rdone, ovr, pre;
  logic [20:0] baddr;
  logic [5:0] div;
  logic [31:0] seed = 32'd72856;
  int n_fail = 0, checks = 0, oe_cnt = 0;
  always #2.5 clock_i = ~clock_i;
  // Counts clocks with the data output enabled, to check the shift window length
  always @(negedge clock_i) if (tdo_oe === 1'b1) oe_cnt++;
  // ID value is arbitrary
  fsrc_top #(.STRETCH_CYCLES(64), .ID_CODE(32'h5a5a_0c01)) i_dut (.clock_i(clock_i),
    .nrst_i(nrst_i), .ce_i(1'b1), .por_n_i(por_n), .ext_rst_n_i(ext_n), .sw_reset_i(sw),
    .watchdog_reset_i(wd), .external_boot_select_i(sel), .sec_byte0_i(b0), .sec_byte1_i(b1),
    .scan_pins_i(pins), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n),
    .erase_done_i(edone), .sys_clk_en_o(clk_en), .periph_rst_n_o(per_n),
    .core_rst_n_o(core_n), .run_o(run), .secured_o(sec), .ext_pspace_block_o(pblk),
    .ext_boot_mode_o(xboot), .debug_enable_o(dbg), .debug_read_disable_o(rdis),
    .boot_addr_o(baddr), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .erase_o(erase),
    .recovery_done_o(rdone), .div_override_o(ovr), .prescale_by_eight_o(pre),
    .flash_divisor_o(div));
  fsrc_jtag_host i_host (.clock_i(clock_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .trst_n_o(trst_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic boot(output int tc, output int tr);
    tc = -1;
    for (tr = 0; tr < 600 && run !== 1'b1; tr++) begin
      @(negedge clock_i);
      if (tc < 0 && clk_en === 1'b1) tc = tr + 1;
    end
    if (run !== 1'b1) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic expect_boot(input logic s);
    check(sec, s);
    check({pblk, rdis, dbg}, {s, s, !s});
    check(xboot, !s && sel);
    check(baddr, (!s && sel) ? `FSRC_BOOT_EXT_ADDR : `FSRC_BOOT_INT_ADDR);
  endtask
  task automatic pin_boot(input logic [15:0] bytes);
    int tc, tr;
    ext_n = 1'b0;
    {b1, b0} = bytes;
    @(negedge clock_i);
    ext_n = 1'b1;
    boot(tc, tr);
  endtask
  initial begin
    int tc, tr;
    logic [31:0] q;
    repeat (3) @(negedge clock_i);
    {b1, b0} = `FSRC_SEC_KEY;
    sel = 1'b1;
    {nrst_i, por_n, ext_n} = 3'h7;
    boot(tc, tr);
    check(tc >= 64 && tc <= 72, 1'b1);
    check(tr - tc, 96);
    expect_boot(1'b1);
    for (int k = 0; k < 2; k++) begin
      q = rnd();
      ext_n = 1'b0;
      {b1, b0} = q[15:0] ^ {15'h0, q[15:0] == `FSRC_SEC_KEY};
      {pins, sel} = {q[31:16], q[16] | (k == 1)};
      @(negedge clock_i);
      check(rdis, 1'b1);
      check({sec, pblk, dbg}, 3'b110);
      i_host.tap_reset();
      tc = oe_cnt;
      i_host.shift(1'b0, 32'h0, 32, q);
      check(q, 32'h5a5a_0c01);
      check(oe_cnt - tc, 8 * 32);
      i_host.shift(1'b1, `FSRC_IR_SAMPLE, 4, q);
      check(q, `FSRC_IR_CAPTURE);
      i_host.shift(1'b0, 32'h0, 16, q);
      check(q, {16'h0, pins});
      i_host.shift(1'b1, `FSRC_IR_BYPASS, 4, q);
      i_host.shift(1'b0, 32'h3, 2, q);
      check(q, 32'h2);
      ext_n = 1'b1;
      boot(tc, tr);
      check(tc <= 8, 1'b1);
      expect_boot(1'b0);
    end
    for (int k = 0; k < 2; k++) begin
      pin_boot({b1, b0});
      repeat (50) @(negedge clock_i);
      check(per_n, 1'b1);
      {wd, sw} = k ? 2'b10 : 2'b01;
      @(negedge clock_i);
      {wd, sw} = 2'b00;
      boot(tc, tr);
      check(tr >= 96 && tr <= 100, 1'b1);
    end
    // Software reset inside the peripheral window restarts from the first window
    ext_n = 1'b0;
    @(negedge clock_i);
    ext_n = 1'b1;
    repeat (40) @(negedge clock_i);
    sw = 1'b1;
    @(negedge clock_i);
    sw = 1'b0;
    boot(tc, tr);
    check(tr, 96);
    pin_boot(`FSRC_SEC_KEY);
    expect_boot(1'b1);
    i_host.tap_reset();
    i_host.recover();
    repeat (2) @(negedge clock_i);
    check(erase, 1'b1);
    i_host.idle(3);
    check(erase, 1'b1);
    check({ovr, pre, div}, 8'hff);
    edone = 1'b1;
    i_host.idle(1);
    check({erase, rdone}, 2'b01);
    edone = 1'b0;
    i_host.tap_reset();
    check(rdone, 1'b0);
    // Mass erase leaves both security bytes erased
    pin_boot(16'hffff);
    expect_boot(1'b0);
    close_out();
  end
endmodule
`default_nettype wire
